// *** qsr_consts.vh ***
`ifndef QSR_CONSTS_VH
`define QSR_CONSTS_VH

// Clock period of CLK in ns
`define QSR_CLK_NS        20
// Least time to whole cycles, never below one
`define QSR_CYC(ns)       ((((ns) + `QSR_CLK_NS - 1) / `QSR_CLK_NS) < 1 ? 1 : \
                           (((ns) + `QSR_CLK_NS - 1) / `QSR_CLK_NS))

// Bus timing in ns
`define QSR_ADDR_SU_NS    40
`define QSR_AS_W_NS       70
`define QSR_ADDR_HOLD_NS  60
`define QSR_DS_W_NS       300
`define QSR_RECOV_NS      60
`define QSR_MIN_CYC_NS    250
`define QSR_RST_HALF_NS   125

// Timing in CLK cycles
`define QSR_ADDR_SU_CYC   `QSR_CYC(`QSR_ADDR_SU_NS)
`define QSR_AS_W_CYC      `QSR_CYC(`QSR_AS_W_NS)
`define QSR_ADDR_HOLD_CYC `QSR_CYC(`QSR_ADDR_HOLD_NS)
`define QSR_DS_W_CYC      `QSR_CYC(`QSR_DS_W_NS)
`define QSR_RECOV_CYC     `QSR_CYC(`QSR_RECOV_NS)
`define QSR_MIN_CYC       `QSR_CYC(`QSR_MIN_CYC_NS)
`define QSR_RST_HALF_CYC  `QSR_CYC(`QSR_RST_HALF_NS)

// Address fields
`define QSR_LO_MSB        7
`define QSR_HI_LSB        8
`define QSR_HI_MSB        15
`define QSR_BLK_LSB       12
`define QSR_BLK_MSB       15
// Block that selects the RAM
`define QSR_RAM_BLOCK     1

// Reset values
`define QSR_RST_BYTE      8'h00
`define QSR_RST_SEL       8'hff

`endif

// *** qsr_blk_dec.v ***
`timescale 1ns/100ps
`default_nettype none

module qsr_blk_dec
(
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // Top four address bits
    input  wire [3:0] block_decode_bits,
    // Active low block selects
    output reg  [7:0] sel_n_r
);

`include "qsr_consts.vh"

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_sel
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    sel_n_r[i] <= 1'b1;
                else if (ce)
                    sel_n_r[i] <= ~(~block_decode_bits[3] &&
                                    (block_decode_bits[2:0] == i));
            end
        end
    endgenerate

endmodule // qsr_blk_dec

`default_nettype wire

// *** qsr_host.v ***
`timescale 1ns/100ps
`default_nettype none

module qsr_host
(
    // Clock, reset, enable
    input  wire       CLK,
    input  wire       RST,
    input  wire       CE,
    // Bus reset level from the reset pin
    input  wire       BUS_RESET,
    // Request port
    input  wire       REQ,
    input  wire       REQ_WR,
    input  wire [15:0] REQ_ADDR,
    input  wire [7:0] REQ_WDATA,
    output reg        BUSY,
    output reg        ACK,
    output reg  [7:0] RDATA,
    // Multiplexed address/data pins
    input  wire [7:0] AD_IN,
    output reg  [7:0] AD_OUT,
    output reg        AD_OE_N,
    // Upper address port
    output reg  [7:0] ADDR_HI,
    // Bus strobes
    output reg        ADDR_STROBE_N,
    output reg        DATA_STROBE_N,
    output reg        MEM_WE_N,
    // RAM side glue
    output reg        MEM_ADDR_CLOCK,
    output reg  [7:0] LAT_ADDR,
    output reg        RAM_CS_N,
    output reg  [6:0] OTHER_SEL_N
);

`include "qsr_consts.vh"

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_ADDR  = 3'h1;
    localparam [2:0] S_ASLO  = 3'h2;
    localparam [2:0] S_HOLD  = 3'h3;
    localparam [2:0] S_DATA  = 3'h4;
    localparam [2:0] S_RECOV = 3'h5;
    localparam [2:0] S_RST   = 3'h6;

    localparam integer ADDR_SU_I   = `QSR_ADDR_SU_CYC;
    localparam integer AS_W_I      = `QSR_AS_W_CYC;
    localparam integer ADDR_HOLD_I = `QSR_ADDR_HOLD_CYC;
    localparam integer DS_W_I      = `QSR_DS_W_CYC;
    localparam integer RECOV_I     = `QSR_RECOV_CYC;
    localparam integer MIN_CYC_I   = `QSR_MIN_CYC;
    localparam integer RST_HALF_I  = `QSR_RST_HALF_CYC;

    localparam [7:0] ADDR_SU   = ADDR_SU_I[7:0];
    localparam [7:0] AS_W      = AS_W_I[7:0];
    localparam [7:0] ADDR_HOLD = ADDR_HOLD_I[7:0];
    localparam [7:0] DS_W      = DS_W_I[7:0];
    localparam [7:0] RECOV     = RECOV_I[7:0];
    localparam [7:0] MIN_CYC   = MIN_CYC_I[7:0];
    localparam [7:0] RST_HALF  = RST_HALF_I[7:0];

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [7:0]  cnt_r;
    reg  [7:0]  cnt_nxt;
    reg  [7:0]  cyc_r;
    reg  [7:0]  cyc_nxt;
    reg         wr_r;
    reg  [15:0] addr_r;
    reg  [7:0]  wdata_r;
    reg         as_nxt;
    reg         ds_nxt;
    reg         oe_n_nxt;
    reg  [7:0]  ad_nxt;
    reg         ack_nxt;
    reg         rd_take;
    reg         brst_s1_r;
    reg         brst_s2_r;
    reg  [7:0]  ad_s1_r;
    reg  [7:0]  ad_s2_r;
    wire [7:0]  sel_n;

    // Pin synchronisers
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            brst_s1_r <= 1'b0;
            brst_s2_r <= 1'b0;
            ad_s1_r   <= `QSR_RST_BYTE;
            ad_s2_r   <= `QSR_RST_BYTE;
        end
        else if (CE)
        begin
            brst_s1_r <= BUS_RESET;
            brst_s2_r <= brst_s1_r;
            ad_s1_r   <= AD_IN;
            ad_s2_r   <= ad_s1_r;
        end
    end

    // Cycle sequencer
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 8'h01;
        cyc_nxt   = (cyc_r == 8'hff) ? cyc_r : cyc_r + 8'h01;
        as_nxt    = ADDR_STROBE_N;
        ds_nxt    = DATA_STROBE_N;
        oe_n_nxt  = AD_OE_N;
        ad_nxt    = AD_OUT;
        ack_nxt   = 1'b0;
        rd_take   = 1'b0;
        case (state_r)
            S_IDLE:
            begin
                oe_n_nxt = 1'b1;
                if (brst_s2_r)
                begin
                    state_nxt = S_RST;
                    cnt_nxt   = 8'h01;
                    ds_nxt    = 1'b0;
                end
                else if (REQ)
                begin
                    state_nxt = S_ADDR;
                    cnt_nxt   = 8'h01;
                    cyc_nxt   = 8'h01;
                    ad_nxt    = REQ_ADDR[`QSR_LO_MSB:0];
                    oe_n_nxt  = 1'b0;
                end
            end
            S_ADDR:
                if (cnt_r >= ADDR_SU)
                begin
                    state_nxt = S_ASLO;
                    cnt_nxt   = 8'h01;
                    as_nxt    = 1'b0;
                end
            S_ASLO:
                if (cnt_r >= AS_W)
                begin
                    state_nxt = S_HOLD;
                    cnt_nxt   = 8'h01;
                    as_nxt    = 1'b1;
                end
            S_HOLD:
                if (cnt_r >= ADDR_HOLD)
                begin
                    state_nxt = S_DATA;
                    cnt_nxt   = 8'h01;
                    ds_nxt    = 1'b0;
                    ad_nxt    = wdata_r;
                    oe_n_nxt  = ~wr_r;
                end
            S_DATA:
                if (cnt_r >= DS_W)
                begin
                    state_nxt = S_RECOV;
                    cnt_nxt   = 8'h01;
                    ds_nxt    = 1'b1;
                    rd_take   = ~wr_r;
                    ack_nxt   = 1'b1;
                end
            S_RECOV:
            begin
                oe_n_nxt = 1'b1;
                if (cnt_r >= RECOV && cyc_r >= MIN_CYC)
                begin
                    state_nxt = S_IDLE;
                    cnt_nxt   = 8'h00;
                end
            end
            S_RST:
            begin
                oe_n_nxt = 1'b1;
                if (!brst_s2_r)
                begin
                    state_nxt = S_IDLE;
                    cnt_nxt   = 8'h00;
                    as_nxt    = 1'b1;
                    ds_nxt    = 1'b1;
                end
                else if (cnt_r >= RST_HALF)
                begin
                    cnt_nxt = 8'h01;
                    as_nxt  = ~ADDR_STROBE_N;
                end
            end
            default:
            begin
                state_nxt = S_IDLE;
                cnt_nxt   = 8'h00;
                as_nxt    = 1'b1;
                ds_nxt    = 1'b1;
                oe_n_nxt  = 1'b1;
            end
        endcase
    end

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_r        <= S_IDLE;
            cnt_r          <= 8'h00;
            cyc_r          <= 8'h00;
            wr_r           <= 1'b0;
            addr_r         <= 16'h0000;
            wdata_r        <= `QSR_RST_BYTE;
            BUSY           <= 1'b0;
            ACK            <= 1'b0;
            RDATA          <= `QSR_RST_BYTE;
            AD_OUT         <= `QSR_RST_BYTE;
            AD_OE_N        <= 1'b1;
            ADDR_HI        <= `QSR_RST_BYTE;
            ADDR_STROBE_N  <= 1'b1;
            DATA_STROBE_N  <= 1'b1;
            MEM_WE_N       <= 1'b1;
            MEM_ADDR_CLOCK <= 1'b1;
            LAT_ADDR       <= `QSR_RST_BYTE;
        end
        else if (CE)
        begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            cyc_r         <= cyc_nxt;
            ACK           <= ack_nxt;
            AD_OUT        <= ad_nxt;
            AD_OE_N       <= oe_n_nxt;
            ADDR_STROBE_N <= as_nxt;
            DATA_STROBE_N <= ds_nxt;
            BUSY          <= (state_nxt != S_IDLE);
            if (state_r == S_IDLE && state_nxt == S_ADDR)
            begin
                wr_r     <= REQ_WR;
                addr_r   <= REQ_ADDR;
                wdata_r  <= REQ_WDATA;
                ADDR_HI  <= REQ_ADDR[`QSR_HI_MSB:`QSR_HI_LSB];
                MEM_WE_N <= ~REQ_WR;
            end
            else if (state_nxt == S_IDLE || state_nxt == S_RST)
                MEM_WE_N <= 1'b1;
            if (rd_take)
                RDATA <= ad_s2_r;
            // Strobe gated by reset
            MEM_ADDR_CLOCK <= as_nxt | brst_s2_r;
            if (!as_nxt && !brst_s2_r)
                LAT_ADDR <= addr_r[`QSR_LO_MSB:0];
        end
    end

    // Block select decode
    qsr_blk_dec u_dec
    (
        .clk               (CLK),
        .rst               (RST),
        .ce                (CE),
        .block_decode_bits (ADDR_HI[`QSR_BLK_MSB-`QSR_HI_LSB:`QSR_BLK_LSB-`QSR_HI_LSB]),
        .sel_n_r           (sel_n)
    );

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RAM_CS_N    <= 1'b1;
            OTHER_SEL_N <= 7'h7f;
        end
        else if (CE)
        begin
            RAM_CS_N    <= sel_n[`QSR_RAM_BLOCK];
            OTHER_SEL_N <= {sel_n[7:2], 1'b1};
        end
    end

endmodule // qsr_host

`default_nettype wire

// *** qsr_host_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module qsr_host_assertions
(
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       BUS_RESET,
    // Handshake
    input wire logic       BUSY,
    input wire logic       ACK,
    // Bus pins
    input wire logic [7:0] AD_OUT,
    input wire logic       AD_OE_N,
    input wire logic [7:0] ADDR_HI,
    input wire logic       ADDR_STROBE_N,
    input wire logic       DATA_STROBE_N,
    input wire logic       MEM_WE_N,
    // Glue outputs
    input wire logic       MEM_ADDR_CLOCK,
    input wire logic [7:0] LAT_ADDR,
    input wire logic       RAM_CS_N,
    input wire logic [6:0] OTHER_SEL_N
);
    logic [4:0] br_r;
    logic       calm;
    // Quiet once bus reset has been low for a while
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
            br_r <= 5'h1f;
        else
            br_r <= {br_r[3:0], BUS_RESET};
    end
    assign calm = (br_r == 5'h00) && !BUS_RESET;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    AST_AC_HELD: assert property (BUS_RESET [*4] |-> MEM_ADDR_CLOCK)
        else $error("address clock active in bus reset");
    AST_AC_GATE: assert property (!MEM_ADDR_CLOCK |-> !ADDR_STROBE_N)
        else $error("address clock low without strobe");
    AST_WE_PASS: assert property (calm && !DATA_STROBE_N |-> $stable(MEM_WE_N))
        else $error("write enable moved in data strobe");
    AST_DS_ACK: assert property (calm && $fell(DATA_STROBE_N) |-> ##15 ACK && DATA_STROBE_N)
        else $error("data strobe width wrong");
    AST_LAT_OPEN: assert property (!ADDR_STROBE_N && !AD_OE_N |-> LAT_ADDR == AD_OUT)
        else $error("latch not open");
    AST_LAT_HOLD: assert property (calm && BUSY && ADDR_STROBE_N && $past(ADDR_STROBE_N)
        |-> $stable(LAT_ADDR))
        else $error("latch not holding");
    AST_HI_HOLD: assert property (calm && BUSY && $past(BUSY) |-> $stable(ADDR_HI))
        else $error("upper address moved");
    AST_SEL_ONE: assert property ($onehot0(~{OTHER_SEL_N, RAM_CS_N}))
        else $error("selects not exclusive");
    AST_BLK0: assert property (calm && !ADDR_STROBE_N && ADDR_HI[7:4] == 4'h0
        |-> RAM_CS_N && OTHER_SEL_N[0] && (&OTHER_SEL_N))
        else $error("block zero selected");
    AST_CS_DEC: assert property (calm && !ADDR_STROBE_N
        |-> RAM_CS_N == (ADDR_HI[7:4] != 4'h1))
        else $error("ram select decode wrong");
    AST_CS_SETUP: assert property ($rose(MEM_ADDR_CLOCK)
        |-> $stable(RAM_CS_N) && RAM_CS_N == $past(RAM_CS_N, 2))
        else $error("select not settled");
    C_WR: cover property (calm && !DATA_STROBE_N && !MEM_WE_N);
    C_RD: cover property (ACK && MEM_WE_N);
    C_BR: cover property (BUS_RESET [*4]);
endmodule // qsr_host_assertions
bind qsr_host qsr_host_assertions i_qsr_host_assertions
(
    .CLK            (CLK),
    .RST            (RST),
    .BUS_RESET      (BUS_RESET),
    .BUSY           (BUSY),
    .ACK            (ACK),
    .AD_OUT         (AD_OUT),
    .AD_OE_N        (AD_OE_N),
    .ADDR_HI        (ADDR_HI),
    .ADDR_STROBE_N  (ADDR_STROBE_N),
    .DATA_STROBE_N  (DATA_STROBE_N),
    .MEM_WE_N       (MEM_WE_N),
    .MEM_ADDR_CLOCK (MEM_ADDR_CLOCK),
    .LAT_ADDR       (LAT_ADDR),
    .RAM_CS_N       (RAM_CS_N),
    .OTHER_SEL_N    (OTHER_SEL_N)
);
`default_nettype wire

// *** qsr_ram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module qsr_ram_model
(
    // Address clock and select
    input  wire logic       ac,
    input  wire logic       cs_n,
    // Strobes
    input  wire logic       we_n,
    input  wire logic       ds_n,
    // Address and data
    input  wire logic [3:0] hi,
    input  wire logic [7:0] bus,
    output logic      [7:0] q,
    output logic            q_oe_n
);
    logic [7:0]  mem [0:4095];
    logic [11:0] addr_r;
    logic        sel_r;
    logic        wr_r;
    // Refresh runs inside the part and never shows here
    always @(posedge ac)
    begin
        addr_r <= {hi, bus};
        sel_r  <= !cs_n;
        wr_r   <= !we_n;
    end
    always @(negedge ds_n)
        wr_r <= wr_r && !we_n;
    always @(posedge ds_n)
    begin
        if (sel_r && wr_r)
            mem[addr_r] <= bus;
    end
    assign q      = mem[addr_r];
    assign q_oe_n = !(sel_r && !wr_r && !ds_n);
endmodule // qsr_ram_model
`default_nettype wire

// *** qsr_host_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module qsr_host_tb_top;
    logic        clk, rst, ce, bus_rst, req, req_wr, busy, ack, ad_oe_n, as_n, ds_n;
    logic        we_n, ac, cs_n, q_oe_n, cs_seen, we_seen;
    logic [15:0] req_addr;
    logic [7:0]  req_wdata, ad_in, ad_out, rdata, addr_hi, lat_addr, q, pat, lat_seen;
    logic [6:0]  oth_n, oth_seen;
    int          fail_count, tests_run;
    qsr_host i_qsr_host (.CLK(clk), .RST(rst), .CE(ce), .BUS_RESET(bus_rst),
        .REQ(req), .REQ_WR(req_wr), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .BUSY(busy), .ACK(ack), .RDATA(rdata), .AD_IN(ad_in), .AD_OUT(ad_out),
        .AD_OE_N(ad_oe_n), .ADDR_HI(addr_hi), .ADDR_STROBE_N(as_n), .DATA_STROBE_N(ds_n),
        .MEM_WE_N(we_n), .MEM_ADDR_CLOCK(ac), .LAT_ADDR(lat_addr), .RAM_CS_N(cs_n),
        .OTHER_SEL_N(oth_n));
    qsr_ram_model i_qsr_ram_model (.ac(ac), .cs_n(cs_n), .we_n(we_n), .ds_n(ds_n),
        .hi(addr_hi[3:0]), .bus(ad_in), .q(q), .q_oe_n(q_oe_n));
    // Released bus shows a changing pattern
    assign ad_in = !ad_oe_n ? ad_out : (!q_oe_n ? q : pat);
    always @(posedge clk)
        pat <= rst ? 8'h00 : pat + 8'h35;
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
    begin
        @(negedge clk);
        req = 1'b1;
        req_wr = wr;
        req_addr = a;
        req_wdata = d;
        for (n = 0; n < 10 && !busy; n++)
            @(negedge clk);
        req = 1'b0;
        for (n = 0; n < 40 && !ack; n++)
        begin
            @(negedge clk);
            if (!as_n)
                {cs_seen, oth_seen} = {cs_n, oth_n};
            if (!ds_n)
                {lat_seen, we_seen} = {lat_addr, we_n};
        end
        chk({7'h00, ack}, 8'h01);
        for (n = 0; n < 10 && busy; n++)
            @(negedge clk);
    end
    endtask
    task automatic t_reset;
    begin
        @(negedge clk);
        chk({4'h0, as_n, ds_n, ac, busy}, 8'h0e);
        chk({cs_n, oth_n}, 8'hff);
        $display("reset test done");
    end
    endtask
    task automatic t_rw;
    begin
        xfer(1'b1, 16'h1234, 8'h5a);
        chk({7'h00, cs_seen}, 8'h00);
        chk(lat_seen, 8'h34);
        chk({7'h00, we_seen}, 8'h00);
        chk(addr_hi, 8'h12);
        xfer(1'b0, 16'h1234, 8'h00);
        chk(rdata, 8'h5a);
        chk({7'h00, we_seen}, 8'h01);
        $display("write read test done");
    end
    endtask
    task automatic t_enable;
    begin
        @(negedge clk);
        ce = 1'b0;
        req = 1'b1;
        req_wr = 1'b0;
        req_addr = 16'h5678;
        repeat (5) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        chk(addr_hi, 8'h12);
        req = 1'b0;
        @(negedge clk);
        ce = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        chk(addr_hi, 8'h12);
        $display("clock enable test done");
    end
    endtask
    task automatic t_decode;
        logic [6:0] eo;
    begin
        for (int b = 0; b < 16; b++)
        begin
            xfer(1'b1, {b[3:0], 12'h234}, {4'ha, b[3:0]});
            eo = 7'h7f;
            if (b >= 2 && b < 8)
                eo[b - 1] = 1'b0;
            chk({cs_seen, oth_seen}, {b != 1, eo});
        end
        xfer(1'b0, 16'h1234, 8'h00);
        chk(rdata, 8'ha1);
        $display("decode test done");
    end
    endtask
    task automatic t_bus_reset;
        integer lo;
        integer tog;
        logic   as_prev;
    begin
        lo = 0;
        tog = 0;
        @(negedge clk);
        bus_rst = 1'b1;
        as_prev = as_n;
        repeat (60)
        begin
            @(negedge clk);
            lo += !ac;
            tog += (as_n != as_prev);
            as_prev = as_n;
        end
        chk(lo[7:0], 8'h00);
        chk({7'h00, tog > 4}, 8'h01);
        chk({7'h00, ds_n}, 8'h00);
        bus_rst = 1'b0;
        repeat (10) @(negedge clk);
        xfer(1'b0, 16'h1234, 8'h00);
        chk(rdata, 8'ha1);
        $display("bus reset test done");
    end
    endtask
    task final_report;
    begin
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        final_report;
    end
    initial
    begin
        {rst, bus_rst, req, req_wr, req_addr, req_wdata} = 28'h8000000;
        {fail_count, tests_run} = 0;
        ce = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_rw;
        t_enable;
        t_decode;
        t_bus_reset;
        final_report;
    end
endmodule // qsr_host_tb_top
`default_nettype wire
